// file: hdl/las_params.svh
// constants for the link audio serial output stage
`ifndef LAS_PARAMS_SVH
`define LAS_PARAMS_SVH

// register byte addresses on the wishbone slave
`define LAS_ADDR_CTRL       8'h00
`define LAS_ADDR_STATUS     8'h04
`define LAS_ADDR_PERIOD     8'h08

// control register field positions
`define LAS_CTRL_CFG_DIS    0
`define LAS_CTRL_PLL_DIS    1
`define LAS_CTRL_OVR        7
`define LAS_CTRL_SEL_LO     4
`define LAS_CTRL_SEL_HI     6

// control reset values
`define LAS_CTRL_RESET      6'h00
`define LAS_RATIO_SHIFT_DEF 2'h1

// clock rate and bit clock limits
`define LAS_REF_CLK_HZ      10000000
`define LAS_BCLK_MIN_HZ     1000000
`define LAS_BCLK_MAX_HZ     13000000
// longest bit period in ref cycles (rounded down)
`define LAS_BCLK_MAX_CYC    (`LAS_REF_CLK_HZ / `LAS_BCLK_MIN_HZ)

// bit period thresholds in ns for the ratio code base
`define LAS_RANGE0_NS       480
`define LAS_RANGE1_NS       240
`define LAS_RANGE2_NS       120
`define LAS_REF_PERIOD_NS   100

`endif

// file: hdl/las_pkg.sv
// types shared by the link audio serial output stage
package las_pkg;

  localparam int SLOT_W = 32;

  typedef enum logic { LAS_ISLAND, LAS_FRAME } las_transport_type;

  typedef struct packed {
    logic       ratio_override;
    logic [2:0] ratio_sel;
    logic       pll_disable;
    logic       cfg_disable;
  } las_ctrl_type;

  // two channels per lane, left in the upper half
  typedef struct packed {
    logic [SLOT_W-1:0] left;
    logic [SLOT_W-1:0] right;
  } las_pair_type;

  typedef struct packed {
    las_pair_type d;
    las_pair_type c;
    las_pair_type b;
    las_pair_type a;
  } las_frame_type;

  typedef struct packed {
    logic       word_select;
    logic [3:0] data;
  } las_serial_type;

endpackage

// file: hdl/las_shifter.sv
// four-lane serial audio shifter, advanced on bit clock falling edges
`timescale 1ns/1ns
`default_nettype none

module las_shifter #(
  parameter int SLOT_W = 32
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic                  fall_pulse,
  input  wire logic [3:0]            lane_en,
  input  wire las_pkg::las_frame_type frame,
  output logic                       frame_taken,
  output las_pkg::las_serial_type    serial
);

  localparam int CNT_W = $clog2(2 * SLOT_W);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(2 * SLOT_W - 1);
  localparam logic [CNT_W-1:0] HALF = CNT_W'(SLOT_W);

  logic [3:0][2*SLOT_W-1:0] sh_q, sh_d;
  logic [CNT_W-1:0]         cnt_q, cnt_d;
  las_pkg::las_serial_type  ser_q, ser_d;
  logic                     taken_q, taken_d;
  logic [3:0][2*SLOT_W-1:0] load;

  assign load[0] = frame.a;
  assign load[1] = frame.b;
  assign load[2] = frame.c;
  assign load[3] = frame.d;

  // data lags word select by one bit so the msb follows each
  // word select change by one period
  always_comb begin
    sh_d    = sh_q;
    cnt_d   = cnt_q;
    ser_d   = ser_q;
    taken_d = 1'b0;
    if (fall_pulse) begin
      cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
      ser_d.word_select = (cnt_d >= HALF);
      for (int i = 0; i < 4; i++) begin
        ser_d.data[i] = sh_q[i][2*SLOT_W-1] & lane_en[i];
        sh_d[i]       = {sh_q[i][2*SLOT_W-2:0], 1'b0};
      end
      if (cnt_q == LAST) begin
        sh_d    = load;
        taken_d = 1'b1;
      end
    end
  end

  // registers only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sh_q    <= '0;
      cnt_q   <= LAST;
      ser_q   <= '0;
      taken_q <= 1'b0;
    end else begin
      sh_q    <= sh_d;
      cnt_q   <= cnt_d;
      ser_q   <= ser_d;
      taken_q <= taken_d;
    end
  end

  assign serial      = ser_q;
  assign frame_taken = taken_q;

endmodule

`default_nettype wire

// file: hdl/las_top.sv
// link audio serial output stage with wishbone control registers
//
// Summary of operation
// - bit clock dropped when slower than 1 MHz; the 13 MHz upper limit is not checked
// - six pins: clock, word select, four data
// - two channels per lane, split by word select
// - legacy serializer: lane A, or A+B at 18-bit
// - default transport is data-island packets
// - transport mode loaded from serializer by default
// - frame transport drives lane A only
// - four lanes only in data-island transport
// - surround needs newer serializer, legacy gets A+B at 18-bit
// - master clock at one, two or four times
// - master clock off while PLL disabled
// - master clock defaults to twice bit clock
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "las_params.svh"
`default_nettype none

module las_top #(
  parameter int SLOT_W   = las_pkg::SLOT_W,
  parameter int PERIOD_W = 12
) (
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  // classic wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  // recovered audio from the link, same clock
  input  wire las_pkg::las_frame_type audio_frame,
  input  wire logic                   audio_valid,
  output logic                        audio_ready,
  input  wire logic                   ser_frame_transport,
  input  wire logic                   ser_legacy,
  input  wire logic                   video_18bit,
  // recovered bit clock, asynchronous to ref_clk
  input  wire logic                   link_bit_clock,
  // audio pins
  output logic                        audio_bit_clock,
  output logic                        channel_word_select,
  output logic                        audio_serial_out_a,
  output logic                        audio_serial_out_b,
  output logic                        audio_serial_out_c,
  output logic                        audio_serial_out_d,
  output logic                        audio_master_clock
);

  // decides the ratio code base from the measured bit period
  function automatic logic [2:0] range_base(input logic [PERIOD_W-1:0] p);
    logic [31:0] ns;
    ns = 32'(p) * `LAS_REF_PERIOD_NS;
    if (ns >= `LAS_RANGE0_NS)      range_base = 3'h0;
    else if (ns >= `LAS_RANGE1_NS) range_base = 3'h1;
    else if (ns >= `LAS_RANGE2_NS) range_base = 3'h2;
    else                           range_base = 3'h3;
  endfunction

  // ---------------- bit clock synchroniser and edges
  logic       bclk_s1_q, bclk_s2_q, bclk_s3_q;
  logic       rise, fall;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
      bclk_s3_q <= 1'b0;
    end else begin
      bclk_s1_q <= link_bit_clock;
      bclk_s2_q <= bclk_s1_q;
      bclk_s3_q <= bclk_s2_q;
    end
  end

  assign rise = bclk_s2_q & ~bclk_s3_q;
  assign fall = ~bclk_s2_q & bclk_s3_q;

  // ---------------- bit period measurement
  logic [PERIOD_W-1:0] per_cnt_q, per_cnt_d;
  logic [PERIOD_W-1:0] period_q, period_d;
  logic                in_range_q, in_range_d;

  // counter saturates so a stopped clock reads as too slow
  always_comb begin
    per_cnt_d  = per_cnt_q;
    period_d   = period_q;
    in_range_d = in_range_q;
    if (per_cnt_q != '1)
      per_cnt_d = per_cnt_q + 1'b1;
    if (rise) begin
      per_cnt_d  = PERIOD_W'(1);
      period_d   = per_cnt_q;
      // slower than the floor is out of range
      in_range_d = (per_cnt_q <= PERIOD_W'(`LAS_BCLK_MAX_CYC));
    end else if (per_cnt_q > PERIOD_W'(`LAS_BCLK_MAX_CYC)) begin
      in_range_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      per_cnt_q  <= '0;
      period_q   <= '0;
      in_range_q <= 1'b0;
    end else begin
      per_cnt_q  <= per_cnt_d;
      period_q   <= period_d;
      in_range_q <= in_range_d;
    end
  end

  // ---------------- control register and wishbone slave
  las_pkg::las_ctrl_type ctrl_q, ctrl_d;
  logic [31:0]           dat_q, dat_d;
  logic                  ack_q, ack_d;
  logic                  req;
  logic [3:0]            lane_en;
  las_pkg::las_transport_type mode;

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;

  // ack one cycle after the request, dropped the next cycle;
  // a write lands only at the edge that sees ack high
  always_comb begin
    ctrl_d = ctrl_q;
    dat_d  = dat_q;
    ack_d  = req;
    if (wb_cyc_i && wb_stb_i && ack_q && wb_we_i &&
        wb_adr_i == `LAS_ADDR_CTRL && wb_sel_i[0]) begin
      ctrl_d.cfg_disable    = wb_dat_i[`LAS_CTRL_CFG_DIS];
      ctrl_d.pll_disable    = wb_dat_i[`LAS_CTRL_PLL_DIS];
      ctrl_d.ratio_override = wb_dat_i[`LAS_CTRL_OVR];
      ctrl_d.ratio_sel = wb_dat_i[`LAS_CTRL_SEL_HI:`LAS_CTRL_SEL_LO];
    end
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        `LAS_ADDR_CTRL: begin
          dat_d = '0;
          dat_d[`LAS_CTRL_CFG_DIS] = ctrl_q.cfg_disable;
          dat_d[`LAS_CTRL_PLL_DIS] = ctrl_q.pll_disable;
          dat_d[`LAS_CTRL_OVR]     = ctrl_q.ratio_override;
          dat_d[`LAS_CTRL_SEL_HI:`LAS_CTRL_SEL_LO] = ctrl_q.ratio_sel;
        end
        `LAS_ADDR_STATUS:
          dat_d = {24'h0, lane_en, 1'b0, in_range_q, ser_legacy,
                   mode == las_pkg::LAS_FRAME};
        `LAS_ADDR_PERIOD:
          dat_d = 32'(period_q);
        default:
          dat_d = '0; // unmapped reads zero, writes dropped
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= las_pkg::las_ctrl_type'(`LAS_CTRL_RESET);
      dat_q  <= '0;
      ack_q  <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      dat_q  <= dat_d;
      ack_q  <= ack_d;
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;

  // ---------------- transport and lane selection
  // serializer choice applies unless software disables it
  always_comb begin
    mode = (ser_frame_transport || ctrl_q.cfg_disable) ?
           las_pkg::LAS_FRAME : las_pkg::LAS_ISLAND;
    if (mode == las_pkg::LAS_FRAME)
      lane_en = 4'h1;
    else if (ser_legacy)
      lane_en = video_18bit ? 4'h3 : 4'h1;
    else
      lane_en = 4'hf;
  end

  // ---------------- sample holding register
  las_pkg::las_frame_type hold_q, hold_d;
  logic                   full_q, full_d;
  logic                   ready_q, ready_d;
  logic                   taken;

  // one frame held; new samples wait until the shifter takes it
  always_comb begin
    hold_d = hold_q;
    full_d = full_q & ~taken;
    if (audio_valid && !full_d) begin
      hold_d = audio_frame;
      full_d = 1'b1;
    end
    ready_d = ~full_d; // ready pin kept on its own flop
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_q  <= '0;
      full_q  <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      hold_q  <= hold_d;
      full_q  <= full_d;
      ready_q <= ready_d;
    end
  end

  assign audio_ready = ready_q;

  // ---------------- serial shifter
  las_pkg::las_serial_type serial;

  las_shifter #(
    .SLOT_W      (SLOT_W)
  ) u_shifter (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .fall_pulse  (fall & in_range_q),
    .lane_en     (lane_en),
    .frame       (hold_q),
    .frame_taken (taken),
    .serial      (serial)
  );

  // ---------------- master clock ratio
  logic [1:0]          shift;
  logic [2:0]          base;
  logic [PERIOD_W-1:0] half_lim;

  // code minus range base gives the ratio step
  always_comb begin
    base  = range_base(period_q);
    shift = `LAS_RATIO_SHIFT_DEF;
    if (ctrl_q.ratio_override) begin
      if (ctrl_q.ratio_sel <= base)
        shift = 2'h0;
      else if (ctrl_q.ratio_sel - base >= 3'h2)
        shift = 2'h2;
      else
        shift = 2'((ctrl_q.ratio_sel - base));
    end
    half_lim = period_q >> (shift + 2'h1);
    if (half_lim == '0)
      half_lim = PERIOD_W'(1); // limited by ref_clk resolution
  end

  logic [PERIOD_W-1:0] m_cnt_q, m_cnt_d;
  logic                mclk_q, mclk_d;

  // realigned on every bit clock rise, held low while PLL is off
  always_comb begin
    m_cnt_d = m_cnt_q + 1'b1;
    mclk_d  = mclk_q;
    if (m_cnt_d >= half_lim) begin
      m_cnt_d = '0;
      mclk_d  = ~mclk_q;
    end
    if (rise) begin
      m_cnt_d = '0;
      mclk_d  = 1'b1;
    end
    if (ctrl_q.pll_disable || !in_range_q) begin
      m_cnt_d = '0;
      mclk_d  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      m_cnt_q <= '0;
      mclk_q  <= 1'b0;
    end else begin
      m_cnt_q <= m_cnt_d;
      mclk_q  <= mclk_d;
    end
  end

  // ---------------- pin registers
  logic bclk_out_q;

  // bit clock regenerated only when within range taken
  // from the second stage so the pin falls in the cycle that data and
  // word select move, and rises with the master clock
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      bclk_out_q <= 1'b0;
    else
      bclk_out_q <= bclk_s2_q & in_range_q;
  end

  // six audio pins plus the master clock
  assign audio_bit_clock     = bclk_out_q;
  assign channel_word_select = serial.word_select;
  assign audio_serial_out_a  = serial.data[0];
  assign audio_serial_out_b  = serial.data[1];
  assign audio_serial_out_c  = serial.data[2];
  assign audio_serial_out_d  = serial.data[3];
  assign audio_master_clock  = mclk_q;

endmodule

`default_nettype wire

// file: verif/las_dac_model.sv
// four-lane serial audio receiver standing in for the dac
`timescale 1ns/1ns
`default_nettype none
module las_dac_model (
  input wire logic       audio_bit_clock,
  input wire logic       channel_word_select,
  input wire logic [3:0] lanes
);
  logic [31:0] sh [4];
  logic [31:0] left [4];
  logic [31:0] right [4];
  logic        ws_q = 1'b0;
  logic        end_q = 1'b0;
  int          words = 0;
  // sample on rise; a word closes one bit after select turns and is
  // kept before the next word's msb is shifted in
  always @(posedge audio_bit_clock) begin
    for (int i = 0; i < 4; i++) begin
      if (end_q && ws_q) left[i] = sh[i];
      if (end_q && !ws_q) right[i] = sh[i];
      sh[i] = {sh[i][30:0], lanes[i]};
    end
    if (end_q) words++;
    end_q = channel_word_select != ws_q;
    ws_q = channel_word_select;
  end
endmodule
`default_nettype wire

// file: verif/las_top_chk.sv
// port assertions for the link audio serial output stage
`timescale 1ns/1ns
`include "las_params.svh"
`default_nettype none
module las_top_chk (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        ser_frame_transport,
  input wire logic        ser_legacy,
  input wire logic        video_18bit,
  input wire logic        link_bit_clock,
  input wire logic        audio_bit_clock,
  input wire logic        channel_word_select,
  input wire logic        audio_serial_out_a,
  input wire logic        audio_serial_out_b,
  input wire logic        audio_serial_out_c,
  input wire logic        audio_serial_out_d,
  input wire logic        audio_master_clock
);
  logic [1:0] ctl_q, ctl_d;
  logic [2:0] mode_q, mode_d;
  logic [9:0] cnt_q, cnt_d;
  // control shadow; the counter waits out a frame already in flight
  always_comb begin
    ctl_d = ctl_q;
    if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `LAS_ADDR_CTRL)
      ctl_d = wb_dat_i[1:0];
    mode_d = {ser_frame_transport | ctl_q[0], ser_legacy, video_18bit};
    cnt_d = cnt_q + {9'h000, cnt_q != 10'h3ff};
    if (mode_d != mode_q)
      cnt_d = 10'h000;
  end
  // register the shadow state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= 2'h0;
      mode_q <= 3'h0;
      cnt_q <= 10'h000;
    end else begin
      ctl_q <= ctl_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  bclk_follow_a:
    assert property ($rose(audio_bit_clock) |-> $past(link_bit_clock, 2))
    else $error("bit clock rise without link clock");
  mclk_off_a:
    assert property (ctl_q[1] && $past(ctl_q[1], 2) |-> !audio_master_clock)
    else $error("master clock on with pll disabled");
  ws_fall_a:
    assert property ($changed(channel_word_select) |-> !audio_bit_clock)
    else $error("word select moved while bit clock high");
  data_fall_a:
    assert property ($changed(audio_serial_out_a) |-> !audio_bit_clock)
    else $error("data moved while bit clock high");
  frame_lanes_a:
    assert property (cnt_q > 10'h2bc && mode_q[2] |->
      !(audio_serial_out_b | audio_serial_out_c | audio_serial_out_d))
    else $error("extra lane active in frame transport");
  legacy_lanes_a:
    assert property (cnt_q > 10'h2bc && mode_q[1] |->
      !(audio_serial_out_c | audio_serial_out_d)
      && (mode_q[0] || !audio_serial_out_b))
    else $error("extra lane active with legacy serializer");
endmodule
bind las_top las_top_chk u_las_top_chk (.ref_clk, .reset_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
  .ser_frame_transport, .ser_legacy, .video_18bit, .link_bit_clock,
  .audio_bit_clock, .channel_word_select, .audio_serial_out_a,
  .audio_serial_out_b, .audio_serial_out_c, .audio_serial_out_d,
  .audio_master_clock);
`default_nettype wire

// file: verif/las_top_test.sv
// register and audio lane tests for the serial output stage
`timescale 1ns/1ns
`include "las_params.svh"
`default_nettype none
module las_top_test;
  logic ref_clk = 1'b0, reset_n = 1'b0, link_bit_clock = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, audio_valid = 1'b1, audio_ready;
  las_pkg::las_frame_type audio_frame;
  logic ser_frame_transport = 1'b0, ser_legacy = 1'b0, video_18bit = 1'b0;
  logic audio_bit_clock, channel_word_select, audio_master_clock;
  logic audio_serial_out_a, audio_serial_out_b;
  logic audio_serial_out_c, audio_serial_out_d;
  int err_count = 0, checks = 0, lhalf = 400;
  logic [15:0] modes [5] = '{16'h000f, 16'h0401, 16'h1001,
                             16'h0201, 16'h0303};
  las_top u_las_top (.ref_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .audio_frame,
    .audio_valid, .audio_ready, .ser_frame_transport, .ser_legacy,
    .video_18bit, .link_bit_clock, .audio_bit_clock, .channel_word_select,
    .audio_serial_out_a, .audio_serial_out_b, .audio_serial_out_c,
    .audio_serial_out_d, .audio_master_clock);
  las_dac_model u_las_dac_model (.audio_bit_clock, .channel_word_select,
    .lanes({audio_serial_out_d, audio_serial_out_c,
            audio_serial_out_b, audio_serial_out_a}));
  // free-running clocks, link clock edges land on ref_clk falling edges
  always #50 ref_clk = ~ref_clk;
  always #(lhalf) link_bit_clock = ~link_bit_clock;
  function automatic logic [31:0] word(input int i, input int c);
    return {8'h80, 8'(i), 8'(c), 8'h5b};
  endfunction
  task automatic complete_run;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, got);
    checks++;
    if (got !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, got);
    end
  endtask
  // one classic cycle; ack sampled at the edge that ends it
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
    repeat (16) @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  // rises of bit clock or master clock over eight bit periods
  task automatic rises(input logic bc, input int x, string nm);
    int r;
    logic m, s;
    r = 0;
    m = bc ? audio_bit_clock : audio_master_clock;
    repeat (64) begin
      @(posedge ref_clk);
      s = bc ? audio_bit_clock : audio_master_clock;
      if (s === 1'b1 && m === 1'b0) r++;
      m = s;
    end
    chk(nm, 32'(8 * x), 32'(r));
  endtask
  initial begin
    #3_000_000;
    err_count++;
    complete_run();
  end
  initial begin
    int w, n;
    for (int i = 0; i < 4; i++)
      audio_frame[64*i +: 64] = {word(i, 0), word(i, 1)};
    repeat (2) @(posedge ref_clk);
    chk("ready in reset", 32'h1, {31'h0, audio_ready});
    @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (40) @(posedge ref_clk);
    rd(`LAS_ADDR_CTRL, 32'h0, "ctrl reset");
    wr(8'h10, 32'hffffffff);
    rd(8'h10, 32'h0, "unmapped");
    rd(`LAS_ADDR_CTRL, 32'h0, "ctrl kept");
    rd(`LAS_ADDR_PERIOD, 32'h8, "period");
    rises(1'b1, 1, "bit clock");
    rises(1'b0, 2, "mclk default");
    for (int s = 0; s < 4; s++) begin
      wr(`LAS_ADDR_CTRL, 32'h80);
      wr(`LAS_ADDR_CTRL, {24'h0, 1'b1, 3'(s), 4'h0});
      rises(1'b0, s == 0 ? 1 : s == 1 ? 2 : 4, "mclk ratio");
    end
    // modes: cfg, frame, legacy, 18-bit, then expected lanes d..a
    foreach (modes[k]) begin
      wr(`LAS_ADDR_CTRL, {31'h0, modes[k][12]});
      {ser_frame_transport, ser_legacy, video_18bit} <= modes[k][10:8];
      w = u_las_dac_model.words;
      n = 0;
      while (u_las_dac_model.words < w + 6 && n < 4000) begin
        @(posedge ref_clk);
        n++;
      end
      if (n >= 4000) err_count++; // words stopped arriving
      for (int i = 0; i < 4; i++) begin
        chk("left", modes[k][i] ? word(i, 0) : 32'h0,
            u_las_dac_model.left[i]);
        chk("right", modes[k][i] ? word(i, 1) : 32'h0,
            u_las_dac_model.right[i]);
      end
      rd(`LAS_ADDR_STATUS, {24'h0, modes[k][3:0], 2'b01, modes[k][9],
         modes[k][12] | modes[k][10]}, "status");
    end
    {ser_frame_transport, ser_legacy, video_18bit} <= 3'b000;
    wr(`LAS_ADDR_CTRL, 32'h2);
    rises(1'b0, 0, "mclk pll off");
    lhalf = 1000;
    repeat (200) @(posedge ref_clk);
    rises(1'b1, 0, "slow bit clock");
    rd(`LAS_ADDR_STATUS, 32'hf0, "out of range");
    lhalf = 400;
    repeat (100) @(posedge ref_clk);
    wr(`LAS_ADDR_CTRL, 32'h0);
    rises(1'b0, 2, "mclk back on");
    complete_run();
  end
endmodule
`default_nettype wire
